// ==== hw/rdc_defs.svh ====
// How it works
// R1: Five-bit level select picks one of 32 levels.
// R2: Enable bit 7 turns converter on.
// R3: Enabled output is ratiometric code over 32.
// R4: Disabled, rail high, code 11111 gives positive source.
// R5: Rail bit set drops negative ladder source.
// R6: Rail bit clear drops positive ladder source.
// R7: Bit 5 routes level onto output pin.
// R8: Pin routing disables digital buffer and input.
// R9: Port read of routed pin returns zero.
// R10: Bits 3-2 choose positive source.
// R11: Bit 0 chooses negative source.
// R12: Level offered to comparator, ADC, pin, sensing.
// R13: Unimplemented bits read as zero.
// R14: Sleep wake leaves control untouched.
// R15: Reset clears all control bits.
// R16: Software should disable converter before sleep.
// R17: Reserved positive code takes no extra action.
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH
`define RDC_CTRL0_ADDR    12'h000
`define RDC_LEVEL_ADDR    12'h004
`define RDC_ADDR_MSB      11
`define RDC_CTRL0_MASK    8'hed
`define RDC_LEVEL_MASK    8'h1f
`define RDC_CTRL0_RESET   8'h00
`define RDC_LEVEL_RESET   8'h00
`define RDC_BIT_ENABLE    7
`define RDC_BIT_RAIL      6
`define RDC_BIT_PINOE     5
`define RDC_PSS_HI        3
`define RDC_PSS_LO        2
`define RDC_BIT_NSS       0
`define RDC_LEVEL_TOP     5'h1f
`define RDC_LEVEL_BOTTOM  5'h00
`endif

// ==== hw/rdc_pkg.sv ====
package rdc_pkg;
   typedef enum logic [1:0] {
      RDC_PSRC_SUPPLY   = 2'b00,
      RDC_PSRC_EXTREF   = 2'b01,
      RDC_PSRC_FIXEDREF = 2'b10,
      RDC_PSRC_RESERVED = 2'b11
   } rdc_psrc_t;
   typedef enum logic [1:0] {
      RDC_OUT_LADDER = 2'b00,
      RDC_OUT_POS    = 2'b01,
      RDC_OUT_NEG    = 2'b10,
      RDC_OUT_OPEN   = 2'b11
   } rdc_outmode_t;
endpackage

// ==== hw/rdc_reference_dac_control.sv ====
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "rdc_defs.svh"
module rdc_reference_dac_control (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // AHB-Lite slave.
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Analog ladder control.
   output logic                       converterEnable,
   output logic [4:0]                 levelSelect,
   output rdc_pkg::rdc_psrc_t         positiveSourceSelect,
   output logic                       negativeSourceSelect,
   output logic                       positiveSourceConnect,
   output logic                       negativeSourceConnect,
   output rdc_pkg::rdc_outmode_t      outputMode,
   output logic                       reservedSourceSelected,
   // Consumers of the level.
   output logic                       referenceAvailable,
   // Reference output pin.
   output logic                       referencePinAnalogConnect,
   output logic                       pinDigitalOutputDisable,
   output logic                       pinDigitalInputDisable,
   input  wire logic                  portPinIn,
   output logic                       portPinRead
);
   logic [7:0]  control0;
   logic [7:0]  levelControl;
   logic [7:0]  next_control0;
   logic [7:0]  next_levelControl;
   logic        wrPending;
   logic [11:0] wrAddr;
   logic        next_wrPending;
   logic [11:0] next_wrAddr;
   logic [31:0] next_hrdata;
   logic        portSync1;
   logic        portSync2;
   logic        addrPhase;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrPhase = hsel && hready && htrans[1];

   function automatic logic [7:0] rdc_read_reg(input logic [11:0] a,
                                               input logic [7:0] c0,
                                               input logic [7:0] c1);
      logic [7:0] r;
      r = 8'h00;
      if (a == `RDC_CTRL0_ADDR) begin
         r = c0 & `RDC_CTRL0_MASK; // R13
      end else if (a == `RDC_LEVEL_ADDR) begin
         r = c1 & `RDC_LEVEL_MASK; // R13
      end
      return r;
   endfunction

   // Writes land in the data phase; reads answer with zero wait states.
   // Unmapped addresses read zero and ignore writes. Nothing here reacts
   // to sleep, so a wake leaves the control bits as they were.
   always_comb begin
      next_control0     = control0; // R14
      next_levelControl = levelControl;
      next_wrPending    = addrPhase && hwrite;
      next_wrAddr       = haddr[`RDC_ADDR_MSB:0];
      next_hrdata       = hrdata;
      if (wrPending && wrAddr == `RDC_CTRL0_ADDR) begin
         next_control0 = hwdata[7:0] & `RDC_CTRL0_MASK; // R13
      end
      if (wrPending && wrAddr == `RDC_LEVEL_ADDR) begin
         next_levelControl = hwdata[7:0] & `RDC_LEVEL_MASK; // R1
      end
      if (addrPhase && !hwrite) begin
         next_hrdata = {24'h000000,
                        rdc_read_reg(haddr[`RDC_ADDR_MSB:0], next_control0,
                                     next_levelControl)};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control0     <= `RDC_CTRL0_RESET; // R15
         levelControl <= `RDC_LEVEL_RESET; // R15
         wrPending    <= 1'b0;
         wrAddr       <= 12'h000;
         hrdata       <= 32'h00000000;
      end else begin
         control0     <= next_control0;
         levelControl <= next_levelControl;
         wrPending    <= next_wrPending;
         wrAddr       <= next_wrAddr;
         hrdata       <= next_hrdata;
      end
   end

   // The pin is asynchronous to clk, so it is synchronised first.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portSync1 <= 1'b0;
         portSync2 <= 1'b0;
      end else begin
         portSync1 <= portPinIn;
         portSync2 <= portSync1;
      end
   end

   // Ladder and pin controls are decoded straight from the registers.
   always_comb begin
      converterEnable        = control0[`RDC_BIT_ENABLE]; // R2
      levelSelect            = levelControl[4:0]; // R1
      positiveSourceSelect   = rdc_pkg::rdc_psrc_t'(
                                  control0[`RDC_PSS_HI:`RDC_PSS_LO]); // R10
      // The reserved code is passed through and only flagged.
      reservedSourceSelected = positiveSourceSelect
                               == rdc_pkg::RDC_PSRC_RESERVED; // R17
      negativeSourceSelect   = control0[`RDC_BIT_NSS]; // R11
      if (converterEnable) begin
         positiveSourceConnect = 1'b1; // R3
         negativeSourceConnect = 1'b1;
         outputMode            = rdc_pkg::RDC_OUT_LADDER; // R3
      end else begin
         positiveSourceConnect = control0[`RDC_BIT_RAIL]; // R6
         negativeSourceConnect = !control0[`RDC_BIT_RAIL]; // R5
         outputMode            = rdc_pkg::RDC_OUT_OPEN;
         if (control0[`RDC_BIT_RAIL] && levelSelect == `RDC_LEVEL_TOP) begin
            outputMode = rdc_pkg::RDC_OUT_POS; // R4
         end else if (!control0[`RDC_BIT_RAIL]
                      && levelSelect == `RDC_LEVEL_BOTTOM) begin
            outputMode = rdc_pkg::RDC_OUT_NEG; // R6
         end
      end
      referenceAvailable        = converterEnable
                                  || outputMode != rdc_pkg::RDC_OUT_OPEN; // R12
      referencePinAnalogConnect = control0[`RDC_BIT_PINOE]; // R7
      pinDigitalOutputDisable   = control0[`RDC_BIT_PINOE]; // R8
      pinDigitalInputDisable    = control0[`RDC_BIT_PINOE]; // R8
      portPinRead               = portSync2 && !control0[`RDC_BIT_PINOE]; // R9
   end

   property p_reset_clear;
      @(posedge clk) $rose(reset_n) |-> control0 == 8'h00 && levelControl == 8'h00;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("control not cleared"); // R15

   property p_wr_ctrl;
      @(posedge clk) disable iff (!reset_n)
         (addrPhase && hwrite && haddr[`RDC_ADDR_MSB:0] == `RDC_CTRL0_ADDR) ##1 1'b1
         |=> control0 == ($past(hwdata[7:0]) & `RDC_CTRL0_MASK);
   endproperty
   a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost"); // R13

   property p_level;
      @(posedge clk) disable iff (!reset_n)
         (addrPhase && hwrite && haddr[`RDC_ADDR_MSB:0] == `RDC_LEVEL_ADDR) ##1 1'b1
         |=> levelSelect == $past(hwdata[4:0]) && levelControl[7:5] == 3'h0;
   endproperty
   a_level: assert property (p_level) else $error("level write wrong"); // R1

   property p_enable;
      @(posedge clk) disable iff (!reset_n)
         converterEnable |-> outputMode == rdc_pkg::RDC_OUT_LADDER
         && positiveSourceConnect && negativeSourceConnect;
   endproperty
   a_enable: assert property (p_enable) else $error("enabled ladder wrong"); // R3

   property p_pos_clamp;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && control0[`RDC_BIT_RAIL]
          && levelSelect == `RDC_LEVEL_TOP)
         |-> outputMode == rdc_pkg::RDC_OUT_POS && !negativeSourceConnect
         && positiveSourceConnect;
   endproperty
   a_pos_clamp: assert property (p_pos_clamp) else $error("positive clamp wrong"); // R4

   property p_neg_clamp;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && !control0[`RDC_BIT_RAIL]
          && levelSelect == `RDC_LEVEL_BOTTOM)
         |-> outputMode == rdc_pkg::RDC_OUT_NEG && !positiveSourceConnect
         && negativeSourceConnect;
   endproperty
   a_neg_clamp: assert property (p_neg_clamp) else $error("negative clamp wrong"); // R6

   property p_pin;
      @(posedge clk) disable iff (!reset_n)
         control0[`RDC_BIT_PINOE] |-> referencePinAnalogConnect && pinDigitalOutputDisable
         && pinDigitalInputDisable && !portPinRead;
   endproperty
   a_pin: assert property (p_pin) else $error("pin override wrong"); // R8

   property p_port;
      @(posedge clk) disable iff (!reset_n)
         !control0[`RDC_BIT_PINOE] |-> portPinRead == $past(portSync1);
   endproperty
   a_port: assert property (p_port) else $error("port read wrong"); // R9

   property p_src;
      @(posedge clk) disable iff (!reset_n)
         positiveSourceSelect == control0[`RDC_PSS_HI:`RDC_PSS_LO]
         && negativeSourceSelect == control0[`RDC_BIT_NSS];
   endproperty
   a_src: assert property (p_src) else $error("source select wrong"); // R10

   // The control and level read-back checks skip a write landing in the same cycle, since the
   // read already returns that new value one edge early.
   property p_rd_ctrl;
      @(posedge clk) disable iff (!reset_n)
         (addrPhase && !hwrite && !wrPending
          && haddr[`RDC_ADDR_MSB:0] == `RDC_CTRL0_ADDR)
         |=> hrdata == {24'h000000, $past(control0) & `RDC_CTRL0_MASK};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong"); // R13

   property p_rd_level;
      @(posedge clk) disable iff (!reset_n)
         (addrPhase && !hwrite && !wrPending
          && haddr[`RDC_ADDR_MSB:0] == `RDC_LEVEL_ADDR)
         |=> hrdata == {24'h000000, $past(levelControl) & `RDC_LEVEL_MASK};
   endproperty
   a_rd_level: assert property (p_rd_level) else $error("level read wrong"); // R13

   property p_rd_unmapped;
      @(posedge clk) disable iff (!reset_n)
         (addrPhase && !hwrite && haddr[`RDC_ADDR_MSB:0] != `RDC_CTRL0_ADDR
          && haddr[`RDC_ADDR_MSB:0] != `RDC_LEVEL_ADDR)
         |=> hrdata == 32'h00000000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // R13

   property p_unimpl;
      @(posedge clk) disable iff (!reset_n)
         (control0 & ~`RDC_CTRL0_MASK) == 8'h00
         && (levelControl & ~`RDC_LEVEL_MASK) == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // R13

   // Sleep has no input here, so between writes the registers must not move.
   property p_hold_ctrl;
      @(posedge clk) disable iff (!reset_n)
         !(wrPending && wrAddr == `RDC_CTRL0_ADDR)
         |=> control0 == $past(control0);
   endproperty
   a_hold_ctrl: assert property (p_hold_ctrl) else $error("control changed unasked"); // R14

   property p_hold_level;
      @(posedge clk) disable iff (!reset_n)
         !(wrPending && wrAddr == `RDC_LEVEL_ADDR)
         |=> levelControl == $past(levelControl);
   endproperty
   a_hold_level: assert property (p_hold_level) else $error("level changed unasked"); // R14

   property p_reset_out;
      @(posedge clk) $rose(reset_n) |-> !converterEnable && !referencePinAnalogConnect
         && levelSelect == `RDC_LEVEL_BOTTOM && outputMode == rdc_pkg::RDC_OUT_NEG;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong"); // R15

   property p_disabled;
      @(posedge clk) disable iff (!reset_n)
         !control0[`RDC_BIT_ENABLE] |-> !converterEnable
         && outputMode != rdc_pkg::RDC_OUT_LADDER;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled converter active"); // R2

   property p_rail_set;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && control0[`RDC_BIT_RAIL])
         |-> positiveSourceConnect && !negativeSourceConnect;
   endproperty
   a_rail_set: assert property (p_rail_set) else $error("rail set connect wrong"); // R5

   property p_rail_clear;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && !control0[`RDC_BIT_RAIL])
         |-> !positiveSourceConnect && negativeSourceConnect;
   endproperty
   a_rail_clear: assert property (p_rail_clear) else $error("rail clear connect wrong"); // R6

   property p_open_top;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && control0[`RDC_BIT_RAIL]
          && levelSelect != `RDC_LEVEL_TOP) |-> outputMode == rdc_pkg::RDC_OUT_OPEN;
   endproperty
   a_open_top: assert property (p_open_top) else $error("clamp without top code"); // R4

   property p_open_bottom;
      @(posedge clk) disable iff (!reset_n)
         (!control0[`RDC_BIT_ENABLE] && !control0[`RDC_BIT_RAIL]
          && levelSelect != `RDC_LEVEL_BOTTOM) |-> outputMode == rdc_pkg::RDC_OUT_OPEN;
   endproperty
   a_open_bottom: assert property (p_open_bottom) else $error("clamp without bottom code"); // R6

   property p_pin_off;
      @(posedge clk) disable iff (!reset_n)
         !control0[`RDC_BIT_PINOE] |-> !referencePinAnalogConnect
         && !pinDigitalOutputDisable && !pinDigitalInputDisable;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin not released"); // R7

   property p_pin_buf;
      @(posedge clk) disable iff (!reset_n)
         pinDigitalOutputDisable == referencePinAnalogConnect
         && pinDigitalInputDisable == referencePinAnalogConnect;
   endproperty
   a_pin_buf: assert property (p_pin_buf) else $error("pin buffer override wrong"); // R8

   property p_neg_sel;
      @(posedge clk) disable iff (!reset_n)
         negativeSourceSelect == control0[`RDC_BIT_NSS];
   endproperty
   a_neg_sel: assert property (p_neg_sel) else $error("negative source wrong"); // R11

   property p_src_supply;
      @(posedge clk) disable iff (!reset_n)
         control0[`RDC_PSS_HI:`RDC_PSS_LO] == rdc_pkg::RDC_PSRC_SUPPLY
         |-> positiveSourceSelect == rdc_pkg::RDC_PSRC_SUPPLY && !reservedSourceSelected;
   endproperty
   a_src_supply: assert property (p_src_supply) else $error("supply source wrong"); // R10

   property p_src_fixed;
      @(posedge clk) disable iff (!reset_n)
         control0[`RDC_PSS_HI:`RDC_PSS_LO] == rdc_pkg::RDC_PSRC_FIXEDREF
         |-> positiveSourceSelect == rdc_pkg::RDC_PSRC_FIXEDREF && !reservedSourceSelected;
   endproperty
   a_src_fixed: assert property (p_src_fixed) else $error("fixed source wrong"); // R10

   property p_reserved;
      @(posedge clk) disable iff (!reset_n)
         reservedSourceSelected
         == (control0[`RDC_PSS_HI:`RDC_PSS_LO] == rdc_pkg::RDC_PSRC_RESERVED);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved flag wrong"); // R17

   property p_avail_on;
      @(posedge clk) disable iff (!reset_n)
         converterEnable |-> referenceAvailable;
   endproperty
   a_avail_on: assert property (p_avail_on) else $error("enabled level not offered"); // R12

   property p_avail_off;
      @(posedge clk) disable iff (!reset_n)
         (!converterEnable && outputMode == rdc_pkg::RDC_OUT_OPEN)
         |-> !referenceAvailable;
   endproperty
   a_avail_off: assert property (p_avail_off) else $error("open level offered"); // R12
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "rdc_defs.svh"
module tb;
   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  hsel = 1'b0;
   logic [31:0]           haddr = 32'h0;
   logic [1:0]            htrans = 2'h0;
   logic                  hwrite = 1'b0;
   logic [2:0]            hsize = 3'h2;
   logic [31:0]           hwdata = 32'h0;
   logic                  portPinIn = 1'b0;
   logic [31:0]           hrdata;
   logic                  hreadyout;
   logic                  hresp;
   logic                  converterEnable;
   logic [4:0]            levelSelect;
   rdc_pkg::rdc_psrc_t    positiveSourceSelect;
   logic                  negativeSourceSelect;
   logic                  positiveSourceConnect;
   logic                  negativeSourceConnect;
   rdc_pkg::rdc_outmode_t outputMode;
   logic                  reservedSourceSelected;
   logic                  referenceAvailable;
   logic                  referencePinAnalogConnect;
   logic                  pinDigitalOutputDisable;
   logic                  pinDigitalInputDisable;
   logic                  portPinRead;
   int                    num_errors = 0;
   int                    checks_done = 0;
   int                    cycles = 0;
   logic [7:0]            c0;
   logic [7:0]            c1;
   logic [31:0]           q;

   rdc_reference_dac_control DUT (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .converterEnable,
      .levelSelect, .positiveSourceSelect, .negativeSourceSelect, .positiveSourceConnect,
      .negativeSourceConnect, .outputMode, .reservedSourceSelected, .referenceAvailable,
      .referencePinAnalogConnect, .pinDigitalOutputDisable, .pinDigitalInputDisable,
      .portPinIn, .portPinRead);

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The master waits on hready rather than assuming zero wait states.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr; hsize <= 3'b010;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   function automatic logic [1:0] exp_mode(input logic [7:0] a, input logic [7:0] b);
      if (a[7]) return 2'b00;
      if (a[6] && b[4:0] == 5'h1f) return 2'b01;
      if (!a[6] && b[4:0] == 5'h00) return 2'b10;
      return 2'b11;
   endfunction

   task automatic check_all(input logic [7:0] a, input logic [7:0] b);
      logic [31:0] r;
      bus(1'b0, `RDC_CTRL0_ADDR, 32'h0, r);
      check(r, {24'h0, a & 8'hed});
      bus(1'b0, `RDC_LEVEL_ADDR, 32'h0, r);
      check(r, {24'h0, b & 8'h1f});
      #1;
      check(converterEnable, a[7]);
      check(levelSelect, b[4:0]);
      check(positiveSourceSelect, a[3:2]);
      check(reservedSourceSelected, a[3:2] == 2'b11);
      check(negativeSourceSelect, a[0]);
      check(positiveSourceConnect, a[7] | a[6]);
      check(negativeSourceConnect, a[7] | !a[6]);
      check(outputMode, exp_mode(a, b));
      check(referenceAvailable, exp_mode(a, b) != 2'b11);
      check(referencePinAnalogConnect, a[5]);
      check({pinDigitalOutputDisable, pinDigitalInputDisable}, {2{a[5]}});
      check(portPinRead, a[5] ? 1'b0 : portPinIn);
      check({hresp, hreadyout}, 2'b01);
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      q = $urandom(56);
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      check_all(8'h00, 8'h00);
      for (int i = 0; i < 48; i++) begin
         c0 = 8'($urandom);
         c1 = 8'($urandom);
         // Clamp codes are rare at random, so of every three passes one forces the top end and one the bottom.
         if (i % 3 == 0) c1[4:0] = 5'h1f;
         if (i % 3 == 1) c1[4:0] = 5'h00;
         if (i < 4) c0[3:2] = i[1:0];
         portPinIn <= 1'($urandom);
         bus(1'b1, `RDC_CTRL0_ADDR, {24'($urandom), c0}, q);
         bus(1'b1, `RDC_LEVEL_ADDR, {24'($urandom), c1}, q);
         check_all(c0, c1);
      end
      c0[7] = 1'b0;
      bus(1'b1, `RDC_CTRL0_ADDR, {24'h000000, c0}, q);
      bus(1'b1, 32'h8, 32'hff, q);
      bus(1'b0, 32'h8, 32'h0, q);
      check(q, 32'h0);
      check_all(c0, c1);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      check_all(8'h00, 8'h00);
      report_and_stop();
   end
endmodule
